/* rtl/ebd_regs.svh */
// Purpose: Offsets, fields, reset values and timing counts of the divider block
// Assumes: 50 MHz system clock
// Notes:   Included by the design and the testbench
`ifndef EBD_REGS_SVH
`define EBD_REGS_SVH
`define EBD_OFF_CTRL      4'h0
`define EBD_OFF_ACR       4'h1
`define EBD_OFF_DIVH      4'h2
`define EBD_OFF_DIVL      4'h3
`define EBD_OFF_NVR       4'h4
`define EBD_OFF_DIVHNV    4'h5
`define EBD_OFF_DIVLNV    4'h6
`define EBD_OFF_STAT      4'h7
`define EBD_OFF_LATADR    4'h8
`define EBD_OFF_LATDAT    4'h9
`define EBD_CTRL_PGM      0
`define EBD_CTRL_LAT      1
`define EBD_CTRL_REFSEL   2
`define EBD_CTRL_WAIT     3
`define EBD_CTRL_STOP     4
`define EBD_DIVH_LOCK     7
`define EBD_NV_ERASED     8'hff
`define EBD_NV_OPTION_RST 8'hf0
`define EBD_PGM_TICKS     16'd286
`define EBD_XTAL_HALF     4'd3
`endif

/* rtl/ebd_pkg.sv */
// Purpose: Types for the divider block
// Assumes: Header holds the numbers
// Notes:   One-hot sequence states
package ebd_pkg;
  typedef enum logic [3:0] {
    EBD_IDLE  = 4'b0001,
    EBD_HV    = 4'b0010,
    EBD_HOLD  = 4'b0100,
    EBD_FALL  = 4'b1000
  } ebd_seq_e;
  typedef logic [7:0] ebd_byte_t;
endpackage : ebd_pkg

/* rtl/ebd_divider.sv */
// Purpose: Timebase divider, its nonvolatile copies, option byte and stop handling
// Assumes: Plain register port, one clock, nonvolatile bytes kept as flip-flops
// Notes:   Program/erase takes a fixed count of timebase ticks
// How it works
// RQ1: After reset the option byte is copied into read-only configuration register.
// RQ2: Option byte changes only through latch, enable and timed sequence.
// RQ3: Eleven-bit divisor held in high/low pair configures the timebase divider.
// RQ4: After reset divider high and low load from their nonvolatile bytes.
// RQ5: Lock bit at 0 freezes both divider registers including itself.
// RQ6: While locked, program or erase of divider nonvolatile bytes is refused.
// RQ7: Divisor always readable; writable only when latch is 0 and lock is 1.
// RQ8: Divider counts crystal or bus clock as selected by configuration.
// RQ9: Software sets divisor to reference frequency times 35 us, rounded.
// RQ10: Software avoids programming with a wrong divisor.
// RQ11: Programmed lock 0 in nonvolatile byte reloads 0 at every reset; here every reset also sets that byte back to ff.
// RQ12: Wait mode leaves a running sequence undisturbed.
// RQ13: Software avoids stop mode during a sequence.
// RQ14: Stop with latch and enable halts, drops voltage, resumes, blocks access.
// RQ15: Stop with latch but no enable ends the sequence without resuming.
// RQ16: Stop-interrupted sequence leaves contents not guaranteed; flagged here until the next commit clears it.
// RQ17: Latch bit makes array writes captured for program or erase.
// RQ18: Enable starts high voltage only with latch set and valid capture.
// RQ19: Lock at high bit 7, divisor 10..8 low high bits, 7..0 low register.
// RQ20: One tick each time divisor reference cycles are counted, then restart.
`timescale 1ns/100ps
`include "ebd_regs.svh"
module ebd_divider (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [3:0]        regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [7:0]        regRdata,
  output logic                   hvOn,
  output logic                   timeTick,
  output logic                   accessBlocked
);
  import ebd_pkg::*;

  typedef struct packed {
    logic              booted;
    ebd_byte_t         acr;
    ebd_byte_t         divh;
    ebd_byte_t         divl;
    ebd_byte_t         nvOpt;
    ebd_byte_t         nvDivh;
    ebd_byte_t         nvDivl;
    logic              lat;
    logic              pgm;
    logic              refSel;
    logic              waitMode;
    logic              stopMode;
    logic              valid;
    logic [3:0]        latAdr;
    ebd_byte_t         latDat;
    ebd_seq_e          seq;
    logic [15:0]       seqCnt;
    logic [10:0]       divCnt;
    logic [3:0]        xtalCnt;
    logic              xtalEn;
    logic              tick;
    logic              corrupt;
    logic              done;
    ebd_byte_t         rdata;
  } ebd_state_s;

  ebd_state_s stReg;
  ebd_state_s stNext;

  function automatic logic nvTarget(input logic [3:0] a);
    nvTarget = (a == `EBD_OFF_NVR) || (a == `EBD_OFF_DIVHNV) || (a == `EBD_OFF_DIVLNV);
  endfunction : nvTarget

  function automatic logic divNv(input logic [3:0] a);
    divNv = (a == `EBD_OFF_DIVHNV) || (a == `EBD_OFF_DIVLNV);
  endfunction : divNv

  logic        locked;
  logic [10:0] divisor;
  assign locked  = ~stReg.divh[`EBD_DIVH_LOCK];
  assign divisor = {stReg.divh[2:0], stReg.divl};  // [RQ19]

  always_comb begin
    stNext        = stReg;
    stNext.tick   = 1'b0;
    stNext.done   = 1'b0;
    stNext.rdata  = 8'h00;
    // Reload from nonvolatile bytes once after reset release
    if (!stReg.booted) begin
      stNext.booted = 1'b1;
      stNext.acr    = stReg.nvOpt;  // [RQ1]
      stNext.divh   = stReg.nvDivh; // [RQ4] [RQ11]
      stNext.divl   = stReg.nvDivl; // [RQ4]
    end
    // Crystal reference modelled as a divided enable of the bus clock
    if (stReg.xtalCnt == `EBD_XTAL_HALF) begin
      stNext.xtalCnt = 4'h0;
      stNext.xtalEn  = 1'b1;
    end else begin
      stNext.xtalCnt = stReg.xtalCnt + 4'h1;
      stNext.xtalEn  = 1'b0;
    end
    // Divider runs on bus clock or crystal enable [RQ8]
    if (!stReg.stopMode && (stReg.refSel ? stReg.xtalEn : 1'b1)) begin
      if (stReg.divCnt + 11'd1 >= divisor) begin  // [RQ20]
        stNext.divCnt = 11'd0;
        stNext.tick   = 1'b1;
      end else begin
        stNext.divCnt = stReg.divCnt + 11'd1;
      end
    end
    // Register writes
    if (regWr) begin
      unique case (regAddr)
        `EBD_OFF_CTRL: begin
          stNext.refSel   = regWdata[`EBD_CTRL_REFSEL];
          stNext.waitMode = regWdata[`EBD_CTRL_WAIT];  // [RQ12]
          stNext.stopMode = regWdata[`EBD_CTRL_STOP];
          // Clearing both only clears the enable, giving voltage time to fall
          if (!(stReg.pgm && !regWdata[`EBD_CTRL_LAT]))
            stNext.lat = regWdata[`EBD_CTRL_LAT];  // [RQ17]
          if (!regWdata[`EBD_CTRL_PGM])
            stNext.pgm = 1'b0;
          else if (stReg.lat && stReg.valid && regWdata[`EBD_CTRL_LAT])
            stNext.pgm = 1'b1;  // [RQ18]
        end
        `EBD_OFF_DIVH: if (!locked && !stReg.lat) stNext.divh = regWdata & 8'h87;  // [RQ5] [RQ7]
        `EBD_OFF_DIVL: if (!locked && !stReg.lat) stNext.divl = regWdata;  // [RQ5] [RQ7]
        default: if (stReg.lat && nvTarget(regAddr) && !stReg.pgm) begin
          // Only a writable byte is captured, so a locked target never arms the pump
          if (!(divNv(regAddr) && locked)) begin  // [RQ6]
            stNext.valid  = 1'b1;  // [RQ2]
            stNext.latAdr = regAddr;
            stNext.latDat = regWdata;
          end
        end
      endcase
    end
    if (!stReg.lat && !stNext.lat)
      stNext.valid = 1'b0;
    // Program sequence
    unique case (stReg.seq)
      EBD_IDLE: if (stReg.pgm && stReg.valid && !stReg.stopMode) begin
        stNext.seq    = EBD_HV;
        stNext.seqCnt = 16'h0;
      end
      EBD_HV: begin
        if (stReg.stopMode) begin
          if (stReg.pgm) begin
            stNext.seq = EBD_HOLD;  // [RQ14]
          end else begin
            stNext.seq     = EBD_IDLE;  // [RQ15]
          end
          stNext.corrupt = 1'b1;  // [RQ16]
        end else if (!stReg.pgm) begin
          stNext.seq = EBD_IDLE;
        end else if (stReg.tick) begin
          if (stReg.seqCnt == `EBD_PGM_TICKS - 16'd1) begin
            stNext.seq  = EBD_FALL;
            stNext.done = 1'b1;
          end else begin
            stNext.seqCnt = stReg.seqCnt + 16'h1;
          end
        end
      end
      EBD_HOLD: if (!stReg.stopMode) stNext.seq = EBD_HV;  // [RQ14]
      EBD_FALL: begin
        // Capture is used up, so a still-set enable cannot start a second pass
        stNext.seq   = EBD_IDLE;
        stNext.valid = 1'b0;  // [RQ18]
      end
      default: stNext.seq = EBD_IDLE;
    endcase
    if (stReg.seq == EBD_HV && stReg.pgm && !stReg.stopMode && stNext.seq == EBD_HV
        && stReg.tick && stReg.seqCnt == `EBD_PGM_TICKS - 16'd1) begin
      stNext.seq = EBD_FALL;
    end
    // Timed commit: program clears bits to 0, never sets them
    if (stReg.done) begin
      unique case (stReg.latAdr)
        `EBD_OFF_NVR:    stNext.nvOpt  = stReg.nvOpt & stReg.latDat;
        `EBD_OFF_DIVHNV: stNext.nvDivh = stReg.nvDivh & stReg.latDat;
        default:         stNext.nvDivl = stReg.nvDivl & stReg.latDat;
      endcase
      stNext.corrupt = 1'b0;
    end
    // Reads; data appear the cycle after the strobe
    if (regRd) begin
      unique case (regAddr)
        `EBD_OFF_CTRL:   stNext.rdata = {3'h0, stReg.stopMode, stReg.waitMode, stReg.refSel,
                                         stReg.lat, stReg.pgm};
        `EBD_OFF_ACR:    stNext.rdata = stReg.acr;
        `EBD_OFF_DIVH:   stNext.rdata = stReg.divh;  // [RQ7]
        `EBD_OFF_DIVL:   stNext.rdata = stReg.divl;  // [RQ7]
        `EBD_OFF_NVR:    stNext.rdata = stReg.nvOpt;
        `EBD_OFF_DIVHNV: stNext.rdata = stReg.nvDivh;
        `EBD_OFF_DIVLNV: stNext.rdata = stReg.nvDivl;
        `EBD_OFF_STAT:   stNext.rdata = {4'h0, stReg.seq};
        `EBD_OFF_LATADR: stNext.rdata = {3'h0, stReg.corrupt, stReg.latAdr};
        `EBD_OFF_LATDAT: stNext.rdata = stReg.latDat;
        default:         stNext.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stReg        <= '0;
      stReg.acr    <= `EBD_NV_OPTION_RST;
      stReg.divh   <= `EBD_NV_ERASED;
      stReg.divl   <= `EBD_NV_ERASED;
      stReg.seq    <= EBD_IDLE;
      // Nonvolatile bytes lose content; every reset loads the power-up values
      stReg.nvOpt  <= `EBD_NV_OPTION_RST;
      stReg.nvDivh <= `EBD_NV_ERASED;
      stReg.nvDivl <= `EBD_NV_ERASED;
    end else begin
      stReg <= stNext;
    end
  end

  assign regRdata      = stReg.rdata;
  assign hvOn          = stReg.seq[1];
  assign timeTick      = stReg.tick;
  assign accessBlocked = stReg.seq[1] | stReg.seq[2];

  a_lock_freeze: assert property (@(posedge clk) disable iff (!nrst)  // [RQ5]
    stReg.booted && locked |=> $stable(stReg.divh) && $stable(stReg.divl))
    else $error("Locked divider changed");
  a_lat_blocks: assert property (@(posedge clk) disable iff (!nrst)  // [RQ7]
    stReg.booted && stReg.lat && regWr && regAddr == `EBD_OFF_DIVL |=> $stable(stReg.divl))
    else $error("Divider written while latched");
  a_nv_refused: assert property (@(posedge clk) disable iff (!nrst)  // [RQ6]
    stReg.booted && locked |=> $stable(stReg.nvDivh) && $stable(stReg.nvDivl))
    else $error("Locked nonvolatile divider changed");
  a_boot_load: assert property (@(posedge clk) disable iff (!nrst)  // [RQ4]
    !stReg.booted |=> stReg.divl == $past(stReg.nvDivl) && stReg.acr == $past(stReg.nvOpt))
    else $error("Reload from nonvolatile failed");
  a_tick_period: assert property (@(posedge clk) disable iff (!nrst)  // [RQ20]
    stReg.booted && !stReg.refSel && !stReg.stopMode && divisor == 11'd3 && stReg.tick
    && $stable(divisor) |-> ##1 !timeTick ##1 !stReg.tick)
    else $error("Tick period wrong");
  a_stop_hold: assert property (@(posedge clk) disable iff (!nrst)  // [RQ14]
    stReg.seq == EBD_HV && stReg.stopMode && stReg.pgm |=> stReg.seq == EBD_HOLD && !hvOn)
    else $error("Stop did not hold sequence");
  a_stop_abort: assert property (@(posedge clk) disable iff (!nrst)  // [RQ15]
    stReg.seq == EBD_HV && stReg.stopMode && !stReg.pgm |=> stReg.seq == EBD_IDLE)
    else $error("Stop did not end sequence");
  a_pgm_arm: assert property (@(posedge clk) disable iff (!nrst)  // [RQ18]
    $rose(stReg.pgm) |-> $past(stReg.lat) && $past(stReg.valid))
    else $error("Enable armed without capture");

  // Start of a sequence: armed in idle, then voltage on and access blocked
  sequence s_arm;
    stReg.seq == EBD_IDLE && stReg.pgm && stReg.valid && !stReg.stopMode;
  endsequence
  sequence s_hv_up;
    stReg.seq == EBD_HV && hvOn && accessBlocked;
  endsequence
  a_seq_start: assert property (@(posedge clk) disable iff (!nrst)  // [RQ18]
    s_arm |=> s_hv_up)
    else $error("Armed sequence did not start");
  a_hold_resume: assert property (@(posedge clk) disable iff (!nrst)  // [RQ14]
    stReg.seq == EBD_HOLD && !stReg.stopMode |=> stReg.seq == EBD_HV)
    else $error("Held sequence did not resume");
  a_hold_block: assert property (@(posedge clk) disable iff (!nrst)  // [RQ14]
    stReg.seq == EBD_HOLD |-> accessBlocked && !hvOn)
    else $error("Held sequence not blocking access");
  a_stop_tick: assert property (@(posedge clk) disable iff (!nrst)  // [RQ14]
    stReg.stopMode |=> !timeTick)
    else $error("Timebase ran in stop");
  a_wait_ignored: assert property (@(posedge clk) disable iff (!nrst)  // [RQ12]
    stReg.seq == EBD_HV && stReg.waitMode && stReg.pgm && !stReg.stopMode && !stReg.tick
    |=> stReg.seq == EBD_HV)
    else $error("Wait disturbed sequence");
  a_stop_corrupt: assert property (@(posedge clk) disable iff (!nrst)  // [RQ16]
    stReg.seq == EBD_HV && stReg.stopMode |=> stReg.corrupt)
    else $error("Stop did not flag contents");
  a_fall_idle: assert property (@(posedge clk) disable iff (!nrst)  // [RQ2]
    stReg.seq == EBD_FALL |=> stReg.seq == EBD_IDLE && !stReg.valid)
    else $error("Sequence did not end cleanly");
  a_commit_opt: assert property (@(posedge clk) disable iff (!nrst)  // [RQ2]
    stReg.done && stReg.latAdr == `EBD_OFF_NVR
    |=> stReg.nvOpt == ($past(stReg.nvOpt) & $past(stReg.latDat)))
    else $error("Option byte commit wrong");
  a_commit_divh: assert property (@(posedge clk) disable iff (!nrst)  // [RQ2]
    stReg.done && stReg.latAdr == `EBD_OFF_DIVHNV
    |=> stReg.nvDivh == ($past(stReg.nvDivh) & $past(stReg.latDat)))
    else $error("Divider high commit wrong");
  a_commit_divl: assert property (@(posedge clk) disable iff (!nrst)  // [RQ2]
    stReg.done && stReg.latAdr == `EBD_OFF_DIVLNV
    |=> stReg.nvDivl == ($past(stReg.nvDivl) & $past(stReg.latDat)))
    else $error("Divider low commit wrong");
  a_acr_readonly: assert property (@(posedge clk) disable iff (!nrst)  // [RQ1]
    stReg.booted |=> $stable(stReg.acr))
    else $error("Configuration register changed");
  a_lat_held: assert property (@(posedge clk) disable iff (!nrst)  // [RQ17]
    stReg.pgm && regWr && regAddr == `EBD_OFF_CTRL && !regWdata[`EBD_CTRL_LAT]
    |=> stReg.lat)
    else $error("Latch cleared under enable");
  a_nv_capture_locked: assert property (@(posedge clk) disable iff (!nrst)  // [RQ6]
    stReg.lat && regWr && divNv(regAddr) && locked
    |=> $stable(stReg.latAdr) && $stable(stReg.latDat))
    else $error("Locked divider byte captured");
  a_div_write: assert property (@(posedge clk) disable iff (!nrst)  // [RQ7]
    !locked && !stReg.lat && regWr && regAddr == `EBD_OFF_DIVL
    |=> stReg.divl == $past(regWdata))
    else $error("Divider write lost");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)  // [RQ7]
    !regRd |=> regRdata == 8'h00)
    else $error("Read data without strobe");
  a_boot_lock: assert property (@(posedge clk) disable iff (!nrst)  // [RQ11]
    !stReg.booted && !regWr |=> stReg.divh == $past(stReg.nvDivh))
    else $error("Lock not reloaded");
endmodule : ebd_divider

/* test/ebd_divider_tb.sv */
// Purpose: Self-checking bench for the timebase divider block
// Assumes: Nonvolatile bytes return to power-up values on every reset
// Notes:   Divisor cut to 3 so one program sequence stays under 900 cycles
`timescale 1ns/100ps
`include "ebd_regs.svh"
module ebd_divider_tb;
  localparam int LIMIT = 20000;
  typedef struct {logic [3:0] a; logic [7:0] e;} ebd_row_s;
  logic       clk;
  logic       nrst;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic       hvOn;
  logic       timeTick;
  logic       accessBlocked;
  logic [7:0] last;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         n;
  int         ticks;
  ebd_row_s   rows [8];

  ebd_divider u_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .hvOn(hvOn),
    .timeTick(timeTick), .accessBlocked(accessBlocked));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // A hang in a bounded wait still ends in the single verdict
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      $display("Error at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    @(negedge clk);
    last = regRdata;
    chk(regRdata, e, "read");
  endtask : rd

  task automatic flags(input logic hv, input logic blk);
    @(negedge clk);
    chk({6'h0, hvOn, accessBlocked}, {6'h0, hv, blk}, "flags");
  endtask : flags

  task automatic wait_hv(input logic lvl);
    n = 0;
    while (hvOn !== lvl && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, hvOn}, {7'h0, lvl}, "hv level");
  endtask : wait_hv

  // Spacing in clock cycles between two ticks
  task automatic gap(input logic [7:0] e);
    int k;
    k = 0;
    @(negedge clk);
    while (timeTick !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (timeTick !== 1'b1 && k < 100);
    chk(8'(k), e, "tick gap");
  endtask : gap

  task automatic prog(input logic [3:0] a, input logic [7:0] d, input logic [7:0] c);
    wr(`EBD_OFF_CTRL, 8'h02);
    wr(a, d);
    wr(`EBD_OFF_CTRL, c);
  endtask : prog

  task automatic after_reset();
    foreach (rows[i]) rd(rows[i].a, rows[i].e);
  endtask : after_reset

  initial begin
    nrst = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    rows = '{'{`EBD_OFF_ACR, 8'hf0}, '{`EBD_OFF_DIVH, 8'hff}, '{`EBD_OFF_DIVL, 8'hff},
      '{`EBD_OFF_NVR, 8'hf0}, '{`EBD_OFF_DIVHNV, 8'hff}, '{`EBD_OFF_DIVLNV, 8'hff},
      '{`EBD_OFF_CTRL, 8'h00}, '{4'hf, 8'h00}};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    after_reset();
    wr(`EBD_OFF_ACR, 8'h00);
    rd(`EBD_OFF_ACR, 8'hf0);
    wr(`EBD_OFF_DIVL, 8'h03);
    wr(`EBD_OFF_DIVH, 8'hf8);
    rd(`EBD_OFF_DIVH, 8'h80);
    gap(8'h03);
    wr(`EBD_OFF_CTRL, 8'h04);
    gap(8'h0c);
    wr(`EBD_OFF_CTRL, 8'h02);
    wr(`EBD_OFF_DIVL, 8'h10);
    rd(`EBD_OFF_DIVL, 8'h03);
    wr(`EBD_OFF_CTRL, 8'h03);
    repeat (3) flags(1'b0, 1'b0);
    wr(`EBD_OFF_CTRL, 8'h00);
    // Wait bit set beside the enable must not slow or stop the sequence
    prog(`EBD_OFF_NVR, 8'h3c, 8'h0b);
    wait_hv(1'b1);
    ticks = 0;
    n = 0;
    while (hvOn === 1'b1 && n < 1500) begin
      @(negedge clk);
      n++;
      if (timeTick === 1'b1) ticks++;
    end
    chk(8'((ticks >= 285 && ticks <= 287) ? 1 : 0), 8'h01, "program length");
    wr(`EBD_OFF_CTRL, 8'h02);
    wr(`EBD_OFF_CTRL, 8'h00);
    rd(`EBD_OFF_NVR, 8'h30);
    rd(`EBD_OFF_ACR, 8'hf0);
    prog(`EBD_OFF_DIVLNV, 8'h0f, 8'h03);
    wait_hv(1'b1);
    wr(`EBD_OFF_CTRL, 8'h13);
    @(posedge clk);
    repeat (4) flags(1'b0, 1'b1);
    wr(`EBD_OFF_CTRL, 8'h03);
    wait_hv(1'b1);
    wait_hv(1'b0);
    wr(`EBD_OFF_CTRL, 8'h02);
    wr(`EBD_OFF_CTRL, 8'h00);
    prog(`EBD_OFF_DIVHNV, 8'h00, 8'h03);
    wait_hv(1'b1);
    wr(`EBD_OFF_CTRL, 8'h12);
    repeat (3) @(negedge clk);
    flags(1'b0, 1'b0);
    wr(`EBD_OFF_CTRL, 8'h02);
    repeat (20) flags(1'b0, 1'b0);
    rd(`EBD_OFF_LATADR, 8'h15);
    wr(`EBD_OFF_CTRL, 8'h00);
    // Locking is one-way, so it runs last before the second reset
    rd(`EBD_OFF_DIVLNV, 8'h0f);
    wr(`EBD_OFF_DIVH, 8'h00);
    wr(`EBD_OFF_DIVH, 8'h80);
    wr(`EBD_OFF_DIVL, 8'h07);
    rd(`EBD_OFF_DIVH, 8'h00);
    rd(`EBD_OFF_DIVL, 8'h03);
    prog(`EBD_OFF_DIVLNV, 8'h01, 8'h03);
    repeat (4) flags(1'b0, 1'b0);
    wr(`EBD_OFF_CTRL, 8'h02);
    wr(`EBD_OFF_CTRL, 8'h00);
    rd(`EBD_OFF_DIVLNV, 8'h0f);
    gap(8'h03);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    after_reset();
    complete_run();
  end
endmodule : ebd_divider_tb
